// ### hdl/dac_ctrl_pkg.sv
package dac_ctrl_pkg;

  // Command word fields
  localparam logic [1:0]  REG_CLASS_SFR      = 2'h0;
  localparam logic [4:0]  ADDR_CTRL_REG      = 5'h0c;
  localparam logic [4:0]  ADDR_MON_SELECT    = 5'h0a;
  localparam logic [4:0]  ADDR_SOFT_PD       = 5'h08;
  localparam logic [4:0]  ADDR_SOFT_PU       = 5'h09;
  localparam logic        RW_WRITE           = 1'h0;
  localparam logic        RW_READ            = 1'h1;

  // Control register field positions
  localparam int          POS_PD_OUT_STATE   = 11;
  localparam int          POS_REF_LEVEL      = 10;
  localparam int          POS_BIAS_BOOST     = 9;
  localparam int          POS_REF_SOURCE     = 8;
  localparam int          POS_MON_ENABLE     = 7;
  localparam int          POS_TEMP_GUARD     = 6;
  localparam int          POS_TOGGLE_LSB     = 0;
  localparam int          TOGGLE_GROUPS      = 4;
  localparam int          CHANNELS           = 32;
  localparam int          GROUP_SIZE         = 8;

  // Reset value; the reference level bit is overridden by a variant strap
  localparam logic [11:0] CTRL_RESET         = 12'h800;

  // Monitor source codes
  localparam int          MON_SRC_MSB        = 11;
  localparam int          MON_SRC_LSB        = 6;
  localparam logic [5:0]  MON_LAST_CHANNEL   = 6'h1f;
  localparam logic [5:0]  MON_AUX_FIRST      = 6'h22;
  localparam logic [5:0]  MON_AUX_LAST       = 6'h25;
  localparam logic [5:0]  MON_TRISTATE       = 6'h3f;

  typedef struct packed {
    logic        reg_class_hi;
    logic        reg_class_lo;
    logic        rd_wr;
    logic [4:0]  target_addr_bits;
    logic [11:0] payload_bits;
  } cmd_word_s;

  typedef enum logic [1:0] {
    MON_OFF  = 2'b00,
    MON_CHAN = 2'b01,
    MON_AUX  = 2'b11,
    MON_UNDEF = 2'b10
  } mon_kind_e;

endpackage : dac_ctrl_pkg

// ### hdl/dac_control_and_monitor_select.sv
// How it works
// - SPECIAL_FUNCTION_COMMAND address 01100: write or read control
// - Full twelve payload bits become control contents
// - Bit 11 picks power-down output state
// - Bit 10 picks internal reference level
// - Bit 9 boosts amplifier bias, default off
// - Bit 8 picks internal or external reference
// - Monitor disabled keeps monitor pin three-stated
// - Enable monitor first, then select routes source
// - Thermal guard powers down amps above limit
// - Soft power-up clears thermal shutdown only when cool
// - Bits 5 and 4 have no effect
// - Low four bits enable toggle per group
// - Update strobe flips A/B in toggled groups
// - SPECIAL_FUNCTION_COMMAND address 01010 carries six-bit source
// - Sources 0 to 31 route channel outputs
// - Sources 34-37 route aux; others undefined
// - Source 63 three-states monitor pin
// - Special commands decode only for class 00
// - Register writes rejected during power-down
module dac_control_and_monitor_select (
  input  wire logic                   sys_clk_in,
  input  wire logic                   rst_b_in,
  input  wire logic                   cmd_valid_in,
  input  wire dac_ctrl_pkg::cmd_word_s cmd_word_in,
  input  wire logic                   ref_variant_hi_in,
  input  wire logic                   hw_power_down_in,
  input  wire logic                   over_temp_in,
  input  wire logic                   output_update_strobe_in,
  output logic [11:0]                 read_data_out,
  output logic                        read_valid_out,
  output logic                        pd_output_state_out,
  output logic                        ref_level_select_out,
  output logic                        amp_bias_boost_out,
  output logic                        ref_source_select_out,
  output logic                        amps_powered_out,
  output logic [31:0]                 toggle_enable_out,
  output logic [31:0]                 use_b_code_out,
  output logic                        mon_drive_channel_out,
  output logic                        mon_drive_aux_out,
  output logic [4:0]                  mon_channel_out,
  output logic [1:0]                  mon_aux_index_out,
  output logic                        monitor_output_pin_oe_b_out
);

  localparam int MSB = dac_ctrl_pkg::MON_SRC_MSB;
  localparam int LSB = dac_ctrl_pkg::MON_SRC_LSB;

  logic [11:0] ctrl_q;
  logic [5:0]  mon_src_q;
  logic        mon_set_q;
  logic        soft_pd_q;
  logic        thermal_pd_q;
  logic        strap_done_q;
  logic [2:0]  temp_sync_q;
  logic [2:0]  pd_sync_q;
  logic [2:0]  upd_sync_q;
  logic        temp_hot_q;
  logic        hw_pd_q;
  logic        upd_q;
  logic [31:0] use_b_q;
  logic        powered_down;
  logic        sfr_cmd;
  logic        upd_rise;
  dac_ctrl_pkg::mon_kind_e mon_kind;

  function automatic logic is_sfr(input dac_ctrl_pkg::cmd_word_s w,
                                  input logic [4:0] a);
    is_sfr = ({w.reg_class_hi, w.reg_class_lo} ==
              dac_ctrl_pkg::REG_CLASS_SFR) &&
             (w.target_addr_bits == a);
  endfunction : is_sfr

  function automatic dac_ctrl_pkg::mon_kind_e decode_src(
      input logic [5:0] s);
    if (s <= dac_ctrl_pkg::MON_LAST_CHANNEL) begin
      decode_src = dac_ctrl_pkg::MON_CHAN;
    end else if (s >= dac_ctrl_pkg::MON_AUX_FIRST &&
                 s <= dac_ctrl_pkg::MON_AUX_LAST) begin
      decode_src = dac_ctrl_pkg::MON_AUX;
    end else if (s == dac_ctrl_pkg::MON_TRISTATE) begin
      decode_src = dac_ctrl_pkg::MON_OFF;
    end else begin
      decode_src = dac_ctrl_pkg::MON_UNDEF;
    end
  endfunction : decode_src

  assign sfr_cmd = cmd_valid_in &&
                   {cmd_word_in.reg_class_hi, cmd_word_in.reg_class_lo} ==
                   dac_ctrl_pkg::REG_CLASS_SFR;
  assign powered_down = soft_pd_q | hw_pd_q | thermal_pd_q;

  // Pin-level inputs: three stages, change accepted when last two agree
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      temp_sync_q <= 3'h0;
      pd_sync_q   <= 3'h0;
      upd_sync_q  <= 3'h0;
    end else begin
      temp_sync_q <= {temp_sync_q[1:0], over_temp_in};
      pd_sync_q   <= {pd_sync_q[1:0], hw_power_down_in};
      upd_sync_q  <= {upd_sync_q[1:0], output_update_strobe_in};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      temp_hot_q <= 1'b0;
      hw_pd_q    <= 1'b0;
      upd_q      <= 1'b0;
    end else begin
      if (temp_sync_q[1] == temp_sync_q[2]) begin
        temp_hot_q <= temp_sync_q[2];
      end
      if (pd_sync_q[1] == pd_sync_q[2]) begin
        hw_pd_q <= pd_sync_q[2];
      end
      if (upd_sync_q[1] == upd_sync_q[2]) begin
        upd_q <= upd_sync_q[2];
      end
    end
  end

  assign upd_rise = (upd_sync_q[1] == upd_sync_q[2]) &&
                    upd_sync_q[2] && !upd_q;

  // Control register; reference level strap caught after reset release
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ctrl_q       <= dac_ctrl_pkg::CTRL_RESET;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      ctrl_q[dac_ctrl_pkg::POS_REF_LEVEL] <= ref_variant_hi_in;
      strap_done_q <= 1'b1;
    end else if (sfr_cmd && !powered_down &&
                 cmd_word_in.rd_wr == dac_ctrl_pkg::RW_WRITE &&
                 is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_CTRL_REG)) begin
      ctrl_q <= cmd_word_in.payload_bits;
    end
  end

  // Readback of the whole register, one cycle after the request
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      read_data_out  <= 12'h000;
      read_valid_out <= 1'b0;
    end else begin
      read_valid_out <= sfr_cmd &&
                        cmd_word_in.rd_wr == dac_ctrl_pkg::RW_READ &&
                        is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_CTRL_REG);
      if (sfr_cmd && cmd_word_in.rd_wr == dac_ctrl_pkg::RW_READ &&
          is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_CTRL_REG)) begin
        read_data_out <= ctrl_q;
      end
    end
  end

  // Monitor select; a write while disabled is still stored
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      mon_src_q <= dac_ctrl_pkg::MON_TRISTATE;
      mon_set_q <= 1'b0;
    end else if (sfr_cmd && !powered_down &&
                 cmd_word_in.rd_wr == dac_ctrl_pkg::RW_WRITE &&
                 is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_MON_SELECT)) begin
      mon_src_q <= cmd_word_in.payload_bits[MSB:LSB];
      mon_set_q <= ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE];
    end else if (!ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE]) begin
      mon_set_q <= 1'b0;
    end
  end

  // Power state: soft commands and thermal guard
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      soft_pd_q    <= 1'b0;
      thermal_pd_q <= 1'b0;
    end else begin
      if (ctrl_q[dac_ctrl_pkg::POS_TEMP_GUARD] && temp_hot_q) begin
        thermal_pd_q <= 1'b1;
      end else if (sfr_cmd && !temp_hot_q &&
                   is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_SOFT_PU)) begin
        thermal_pd_q <= 1'b0;
      end
      if (sfr_cmd && is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_SOFT_PD)) begin
        soft_pd_q <= 1'b1;
      end else if (sfr_cmd &&
                   is_sfr(cmd_word_in, dac_ctrl_pkg::ADDR_SOFT_PU)) begin
        soft_pd_q <= 1'b0;
      end
    end
  end

  // Toggle phase per channel; flips only in enabled groups
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      use_b_q <= 32'h0;
    end else if (upd_rise) begin
      for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++) begin
        if (ctrl_q[i / dac_ctrl_pkg::GROUP_SIZE]) begin
          use_b_q[i] <= !use_b_q[i];
        end
      end
    end
  end

  always_comb begin
    for (int i = 0; i < dac_ctrl_pkg::CHANNELS; i++) begin
      toggle_enable_out[i] = ctrl_q[i / dac_ctrl_pkg::GROUP_SIZE];
    end
  end

  // Bits 5 and 4 are stored for readback but drive nothing
  assign pd_output_state_out   = ctrl_q[dac_ctrl_pkg::POS_PD_OUT_STATE];
  assign ref_level_select_out  = ctrl_q[dac_ctrl_pkg::POS_REF_LEVEL];
  assign amp_bias_boost_out    = ctrl_q[dac_ctrl_pkg::POS_BIAS_BOOST];
  assign ref_source_select_out = ctrl_q[dac_ctrl_pkg::POS_REF_SOURCE];
  assign amps_powered_out      = !powered_down;
  assign use_b_code_out        = use_b_q;

  always_comb begin
    mon_kind = decode_src(mon_src_q);
    if (!ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE] || !mon_set_q) begin
      mon_kind = dac_ctrl_pkg::MON_OFF;
    end
  end

  assign mon_drive_channel_out = (mon_kind == dac_ctrl_pkg::MON_CHAN);
  assign mon_drive_aux_out     = (mon_kind == dac_ctrl_pkg::MON_AUX);
  assign mon_channel_out       = mon_src_q[4:0];
  assign mon_aux_index_out     = 2'(mon_src_q - dac_ctrl_pkg::MON_AUX_FIRST);
  assign monitor_output_pin_oe_b_out =
    !(mon_drive_channel_out || mon_drive_aux_out);

  a_ctrl_write_lands: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    strap_done_q && sfr_cmd && !powered_down && !cmd_word_in.rd_wr &&
    cmd_word_in.target_addr_bits == dac_ctrl_pkg::ADDR_CTRL_REG
    |=> ctrl_q == $past(cmd_word_in.payload_bits))
    else $error("control write not stored");

  a_field_outputs: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    strap_done_q && sfr_cmd && !powered_down && !cmd_word_in.rd_wr &&
    cmd_word_in.target_addr_bits == dac_ctrl_pkg::ADDR_CTRL_REG
    |=> {pd_output_state_out, ref_level_select_out, amp_bias_boost_out,
         ref_source_select_out} ==
        $past(cmd_word_in.payload_bits[dac_ctrl_pkg::POS_PD_OUT_STATE:
                                       dac_ctrl_pkg::POS_REF_SOURCE]))
    else $error("control outputs do not follow write");

  a_pd_write_blocked: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    strap_done_q && powered_down |=> ctrl_q == $past(ctrl_q))
    else $error("write accepted in power-down");

  a_soft_pd_enter: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    sfr_cmd && cmd_word_in.target_addr_bits == dac_ctrl_pkg::ADDR_SOFT_PD
    |=> !amps_powered_out)
    else $error("soft power-down not entered");

  a_reset_toggle_off: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !strap_done_q |-> ctrl_q[dac_ctrl_pkg::POS_TOGGLE_LSB +:
                             dac_ctrl_pkg::TOGGLE_GROUPS] == '0)
    else $error("toggle enables not cleared by reset");

  a_readback_value: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    read_valid_out |-> read_data_out == $past(ctrl_q))
    else $error("readback mismatch");

  a_mon_disabled_hiz: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE] |-> monitor_output_pin_oe_b_out)
    else $error("monitor driven while disabled");

  a_route_needs_enable: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE] |=> !mon_set_q)
    else $error("route armed while monitor disabled");

  a_mon_src_stored: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    sfr_cmd && !powered_down && !cmd_word_in.rd_wr &&
    cmd_word_in.target_addr_bits == dac_ctrl_pkg::ADDR_MON_SELECT
    |=> mon_src_q == $past(cmd_word_in.payload_bits[MSB:LSB]))
    else $error("monitor source not stored");

  a_mon_channel_route: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE] && mon_set_q &&
    mon_src_q <= dac_ctrl_pkg::MON_LAST_CHANNEL
    |-> mon_drive_channel_out && !monitor_output_pin_oe_b_out &&
        mon_channel_out == mon_src_q[4:0])
    else $error("channel source not routed");

  a_mon_aux_route: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    ctrl_q[dac_ctrl_pkg::POS_MON_ENABLE] && mon_set_q &&
    mon_src_q >= dac_ctrl_pkg::MON_AUX_FIRST &&
    mon_src_q <= dac_ctrl_pkg::MON_AUX_LAST
    |-> mon_drive_aux_out && !monitor_output_pin_oe_b_out)
    else $error("auxiliary source not routed");

  a_mon_code63_hiz: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    mon_src_q == dac_ctrl_pkg::MON_TRISTATE |-> monitor_output_pin_oe_b_out)
    else $error("code 63 not three-state");

  a_thermal_trip: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    ctrl_q[dac_ctrl_pkg::POS_TEMP_GUARD] && temp_hot_q
    |=> !amps_powered_out)
    else $error("thermal guard did not trip");

  a_hot_no_powerup: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    thermal_pd_q && temp_hot_q |=> thermal_pd_q)
    else $error("power-up while hot");

  a_thermal_release: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    sfr_cmd && !temp_hot_q &&
    cmd_word_in.target_addr_bits == dac_ctrl_pkg::ADDR_SOFT_PU
    |=> !thermal_pd_q)
    else $error("soft power-up did not clear thermal shutdown");

  a_toggle_flip: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    upd_rise && ctrl_q[0] |=> use_b_q[0] != $past(use_b_q[0]))
    else $error("group 0 did not toggle");

  a_toggle_hold: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    !ctrl_q[3] |=> use_b_q[31] == $past(use_b_q[31]))
    else $error("disabled group toggled");

  a_non_sfr_ignored: assert property (@(posedge sys_clk_in)
    disable iff (!rst_b_in)
    strap_done_q && cmd_valid_in &&
    (cmd_word_in.reg_class_hi || cmd_word_in.reg_class_lo)
    |=> ctrl_q == $past(ctrl_q))
    else $error("non-special command decoded");

  c_ctrl_write: cover property (@(posedge sys_clk_in)
    disable iff (!rst_b_in) $changed(ctrl_q) && strap_done_q);
  c_mon_channel: cover property (@(posedge sys_clk_in)
    disable iff (!rst_b_in) mon_drive_channel_out);
  c_mon_aux: cover property (@(posedge sys_clk_in)
    disable iff (!rst_b_in) mon_drive_aux_out);
  c_thermal_recover: cover property (@(posedge sys_clk_in)
    disable iff (!rst_b_in) $fell(thermal_pd_q));
  c_toggle_group1: cover property (@(posedge sys_clk_in)
    disable iff (!rst_b_in) upd_rise && ctrl_q[1]);

endmodule : dac_control_and_monitor_select

// ### verification/host_cmd_model.sv
module host_cmd_model (
  input  wire logic               clk_in,
  output dac_ctrl_pkg::cmd_word_s cmd_word_out,
  output logic                    cmd_valid_out
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    cmd_valid_out = 1'b0;
    cmd_word_out  = '0;
  end

  // One word per command; idle bus shows inverted data, not the last word
  task automatic send(input logic [1:0] cls, input logic rw,
                      input logic [4:0] addr, input logic [11:0] data);
    dac_ctrl_pkg::cmd_word_s w;
    w = {cls, rw, addr, data};
    @(posedge clk_in);
    cmd_valid_out <= 1'b1;
    cmd_word_out  <= w;
    @(posedge clk_in);
    cmd_valid_out <= 1'b0;
    cmd_word_out  <= ~w;
  endtask : send
endmodule : host_cmd_model

// ### verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [11:0] ctrl;
    logic [31:0] tog;
  } row_s;
  logic                    sys_clk_in, rst_b_in, cmd_valid_in;
  dac_ctrl_pkg::cmd_word_s cmd_word_in;
  logic                    ref_variant_hi_in, hw_power_down_in;
  logic                    over_temp_in, output_update_strobe_in;
  logic [11:0]             read_data_out;
  logic                    read_valid_out, pd_output_state_out;
  logic                    ref_level_select_out, amp_bias_boost_out;
  logic                    ref_source_select_out, amps_powered_out;
  logic [31:0]             toggle_enable_out, use_b_code_out;
  logic                    mon_drive_channel_out, mon_drive_aux_out;
  logic [4:0]              mon_channel_out;
  logic [1:0]              mon_aux_index_out;
  logic                    monitor_output_pin_oe_b_out;
  int                      fail_count, num_checks, cycles;
  row_s rows[5] = '{'{12'hfff, 32'hffffffff}, '{12'h000, 32'h0},
                    '{12'ha35, 32'h00ff00ff}, '{12'h50a, 32'hff00ff00},
                    '{12'h008, 32'hff000000}};
  logic [5:0] codes[10] = '{6'h00, 6'h1f, 6'h20, 6'h21, 6'h22, 6'h25,
                            6'h26, 6'h3e, 6'h3f, 6'h11};

  dac_control_and_monitor_select DUT (.sys_clk_in, .rst_b_in, .cmd_valid_in,
    .cmd_word_in, .ref_variant_hi_in, .hw_power_down_in, .over_temp_in,
    .output_update_strobe_in, .read_data_out, .read_valid_out,
    .pd_output_state_out, .ref_level_select_out, .amp_bias_boost_out,
    .ref_source_select_out, .amps_powered_out, .toggle_enable_out,
    .use_b_code_out, .mon_drive_channel_out, .mon_drive_aux_out,
    .mon_channel_out, .mon_aux_index_out, .monitor_output_pin_oe_b_out);
  host_cmd_model host (.clk_in(sys_clk_in), .cmd_word_out(cmd_word_in),
                       .cmd_valid_out(cmd_valid_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : summarize

  // A hang counts as a mismatch and still reaches the report
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] v);
    host.send(2'h0, dac_ctrl_pkg::RW_WRITE, dac_ctrl_pkg::ADDR_CTRL_REG, v);
    #1;
  endtask : wr

  task automatic special_function_command(input logic [4:0] a);
    host.send(2'h0, dac_ctrl_pkg::RW_WRITE, a, 12'h000);
    #1;
  endtask : special_function_command

  task automatic rd_chk(input logic [11:0] exp);
    host.send(2'h0, dac_ctrl_pkg::RW_READ, dac_ctrl_pkg::ADDR_CTRL_REG, 12'h0);
    #1;
    check("read_valid", 32'(read_valid_out), 32'h1);
    check("read_data", 32'(read_data_out), 32'(exp));
  endtask : rd_chk

  task automatic chk_ctrl(input logic [11:0] v, input logic [31:0] tog);
    check("pd_state", 32'(pd_output_state_out), 32'(v[11]));
    check("ref_level", 32'(ref_level_select_out), 32'(v[10]));
    check("boost", 32'(amp_bias_boost_out), 32'(v[9]));
    check("ref_src", 32'(ref_source_select_out), 32'(v[8]));
    check("toggle_en", toggle_enable_out, tog);
  endtask : chk_ctrl

  task automatic wait_sync(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : wait_sync

  initial begin
    logic ch, aux;
    rst_b_in = 1'b0;
    ref_variant_hi_in = 1'b1;
    hw_power_down_in = 1'b0;
    over_temp_in = 1'b0;
    output_update_strobe_in = 1'b0;
    repeat (12) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    wait_sync(2);
    chk_ctrl(12'hc00, 32'h0);
    check("mon_oe_b", 32'(monitor_output_pin_oe_b_out), 32'h1);
    rd_chk(12'hc00);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i].ctrl);
      chk_ctrl(rows[i].ctrl, rows[i].tog);
      rd_chk(rows[i].ctrl);
    end
    // Select before enable must leave the pin released
    wr(12'h000);
    host.send(2'h0, 1'b0, dac_ctrl_pkg::ADDR_MON_SELECT, {6'h05, 6'h2a});
    #1;
    check("mon_oe_b", 32'(monitor_output_pin_oe_b_out), 32'h1);
    wr(12'h080);
    check("mon_oe_b", 32'(monitor_output_pin_oe_b_out), 32'h1);
    foreach (codes[i]) begin
      host.send(2'h0, 1'b0, dac_ctrl_pkg::ADDR_MON_SELECT, {codes[i], 6'h15});
      #1;
      ch = (codes[i] <= 6'h1f);
      aux = (codes[i] >= 6'h22) && (codes[i] <= 6'h25);
      check("mon_ch", 32'(mon_drive_channel_out), 32'(ch));
      check("mon_aux", 32'(mon_drive_aux_out), 32'(aux));
      check("mon_oe_b", 32'(monitor_output_pin_oe_b_out),
            32'(!(ch || aux)));
      if (ch)
        check("mon_sel", 32'(mon_channel_out), 32'(codes[i][4:0]));
      if (aux)
        check("aux_sel", 32'(mon_aux_index_out),
              32'(codes[i] - 6'h22));
    end
    wr(12'h000);
    check("mon_oe_b", 32'(monitor_output_pin_oe_b_out), 32'h1);
    for (int c = 1; c < 4; c++) begin
      host.send(c[1:0], 1'b0, dac_ctrl_pkg::ADDR_CTRL_REG, 12'h123);
      rd_chk(12'h000);
    end
    special_function_command(dac_ctrl_pkg::ADDR_SOFT_PD);
    check("amps_on", 32'(amps_powered_out), 32'h0);
    wr(12'h00f);
    rd_chk(12'h000);
    special_function_command(dac_ctrl_pkg::ADDR_SOFT_PU);
    check("amps_on", 32'(amps_powered_out), 32'h1);
    hw_power_down_in <= 1'b1;
    wait_sync(6);
    check("amps_on", 32'(amps_powered_out), 32'h0);
    hw_power_down_in <= 1'b0;
    over_temp_in <= 1'b1;
    wait_sync(8);
    check("amps_on", 32'(amps_powered_out), 32'h1);
    wr(12'h040);
    wait_sync(8);
    check("amps_on", 32'(amps_powered_out), 32'h0);
    special_function_command(dac_ctrl_pkg::ADDR_SOFT_PU);
    wait_sync(2);
    check("amps_on", 32'(amps_powered_out), 32'h0);
    over_temp_in <= 1'b0;
    wait_sync(8);
    check("amps_on", 32'(amps_powered_out), 32'h0);
    special_function_command(dac_ctrl_pkg::ADDR_SOFT_PU);
    check("amps_on", 32'(amps_powered_out), 32'h1);
    wr(12'h003);
    for (int k = 0; k < 3; k++) begin
      output_update_strobe_in <= 1'b1;
      wait_sync(6);
      check("use_b", use_b_code_out, k[0] ? 32'h0 : 32'h0000ffff);
      output_update_strobe_in <= 1'b0;
      wait_sync(6);
    end
    // Mid-run reset with the low strap clears toggle phase and enables
    rst_b_in <= 1'b0;
    ref_variant_hi_in <= 1'b0;
    wait_sync(3);
    rst_b_in <= 1'b1;
    wait_sync(2);
    chk_ctrl(12'h800, 32'h0);
    check("use_b", use_b_code_out, 32'h0);
    rd_chk(12'h800);
    summarize();
  end
endmodule : tb
